// [design/resq_pkg.sv]
package resq_pkg;
	// register offsets (byte addresses in the register window)
	localparam logic [15:0] RECEIVE_CONFIG_OFS = 16'h0102;
	localparam logic [15:0] QUEUE_OFS = 16'h0120;
	localparam logic [15:0] RECEIVE_EVENT_OFS = 16'h0124;
	localparam logic [15:0] RECEIVE_STATUS_COPY_OFS = 16'h0400;
	localparam logic [15:0] FRAME_LENGTH_OFS = 16'h0402;
	localparam logic [15:0] QUEUE_IO_OFS = 16'h0008;
	// reset values
	localparam logic [15:0] RECEIVE_CONFIG_RST = 16'h0003;
	localparam logic [15:0] QUEUE_RST = 16'h0000;
	// register number codes in bits 5..0
	localparam logic [5:0] NUM_RX_EVENT = 6'h04;
	localparam logic [5:0] NUM_TX_EVENT = 6'h08;
	localparam logic [5:0] NUM_BUF_EVENT = 6'h0c;
	localparam logic [5:0] NUM_MISS_CNT = 6'h10;
	localparam logic [5:0] NUM_COLL_CNT = 6'h12;
	localparam int NUM_SOURCES = 5;
	localparam int SRC_RX = 0;
	localparam int SRC_TX = 1;
	localparam int SRC_BUF = 2;
	localparam int SRC_MISS = 3;
	localparam int SRC_COLL = 4;
	// receive_config bit positions
	localparam int CFG_STREAM = 7;
	localparam int CFG_SKIP = 6;
	localparam int CFG_GOOD_IE = 8;
	localparam int CFG_DMA_ONLY = 9;
	localparam int CFG_AUTO_DMA = 10;
	localparam int CFG_KEEP_FCS = 11;
	localparam int CFG_BAD_FCS_IE = 12;
	localparam int CFG_SHORT_IE = 13;
	localparam int CFG_LONG_IE = 14;
	// receive_event bit positions
	localparam int EV_EXTRA_BITS = 7;
	localparam int EV_HASH_HIT = 6;
	localparam int EV_GOOD = 8;
	localparam int EV_HASHED = 9;
	localparam int EV_OWN = 10;
	localparam int EV_ALL_ONES = 11;
	localparam int EV_BAD_FCS = 12;
	localparam int EV_SHORT = 13;
	localparam int EV_LONG = 14;
	// frame length limits in bytes
	localparam logic [10:0] MIN_FRAME = 11'd64;
	localparam logic [10:0] MAX_FRAME = 11'd1518;
	localparam logic [10:0] DISCARD_BELOW = 11'd8;
	localparam logic [10:0] FCS_BYTES = 11'd4;
	typedef enum logic [1:0] {
		RESQ_DMA_NONE = 2'b00,
		RESQ_DMA_ONLY = 2'b01,
		RESQ_DMA_AUTO = 2'b10
	} resq_path_e;
endpackage

// [design/resq_pend_slot.sv]
`timescale 1ns/1ps
// one pending queue source: holds the OR of all content set since the last take, and a pending flag
module resq_pend_slot (
	input wire logic mclk,
	input wire logic rst,
	input wire logic setReq,
	input wire logic [9:0] setBits,
	input wire logic take,
	output logic pending,
	output logic [9:0] bits
);
	logic pend_ff;
	logic [9:0] bits_ff;

	// a new event arriving with the take wins over the clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend_ff <= 1'b0;
		end else if (setReq) begin
			pend_ff <= 1'b1;
		end else if (take) begin
			pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bits_ff <= 10'h000;
		end else if (setReq) begin
			bits_ff <= (take ? 10'h000 : bits_ff) | setBits;
		end else if (take) begin
			bits_ff <= 10'h000;
		end
	end

	assign pending = pend_ff;
	assign bits = bits_ff;
endmodule

// [design/resq_rx_event_queue.sv]
`timescale 1ns/1ps
// Function
// RULE_01: enabled event sets register bits, copies into queue, raises interrupt request
// RULE_02: queue word holds six-bit register number low, ten content bits high
// RULE_03: queue readable at offset 120h, or io offset 0008h in io mode
// RULE_04: receive event reads return 000100 in its low six bits
// RULE_05: writing one to skip bit deletes last frame once per write
// RULE_06: host never uses skip while dma-only bit is set
// RULE_07: streaming enable uses streaming for back-to-back filtered frames, else never
// RULE_08: host sets streaming only with auto-dma or dma-only set
// RULE_09: good-frame interrupt when enabled, except for frames taken by dma
// RULE_10: dma-only routes all frames to dma; auto-dma switches; dma-only wins
// RULE_11: keep-fcs stores and counts the four fcs bytes; clear excludes them
// RULE_12: enables for bad fcs, short, overlong interrupts; under 8 bytes discarded
// RULE_13: receive config resets to 0003 unless configuration memory supplies value
// RULE_14: hash hit flag needs hash accept, hash accept control and hashed bit
// RULE_15: extra-bits flag for one to seven trailing bits; with bad fcs alignment
// RULE_16: good flag for correct fcs and length; length then readable, interrupt
// RULE_17: hashed and good together make bits F..A the hash index
// RULE_18: own-address flag needs station match, good flag and own accept
// RULE_19: all-ones flag needs all-ones destination, good flag and its accept
// RULE_20: flag bad fcs, short, overlong; drop bytes past 1518; interrupt if enabled
// RULE_21: reading receive event clears it; host handles every bit from one read
// RULE_22: status copy mirrors event, not cleared by read; event undefined in dma-only
// RULE_23: pending sources presented one per queue read; nothing pending reads zero
module resq_rx_event_queue (
	input wire logic mclk,
	input wire logic rst,
	// register access port
	input wire logic ioMode,
	input wire logic [15:0] regAddr,
	input wire logic regRd,
	input wire logic regWr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	// configuration memory load
	input wire logic cfgMemPresent,
	input wire logic cfgMemLoad,
	input wire logic [15:0] cfgMemValue,
	// end of received frame report
	input wire logic frameDone,
	input wire logic [10:0] frameBytes,
	input wire logic fcsOk,
	input wire logic extraBits,
	input wire logic hashAccepted,
	input wire logic [5:0] hashIndex,
	input wire logic stationMatch,
	input wire logic allOnesDest,
	input wire logic multicastDest,
	input wire logic backToBack,
	input wire logic filterPass,
	input wire logic autoDmaCondition,
	// receive control accept bits
	input wire logic stationHashAccept,
	input wire logic ownAddressAccept,
	input wire logic allOnesDestAccept,
	// other queue sources, one-cycle pulses with content
	input wire logic txEventSet,
	input wire logic [9:0] txEventBits,
	input wire logic bufEventSet,
	input wire logic [9:0] bufEventBits,
	input wire logic missOverflowSet,
	input wire logic [9:0] missCountBits,
	input wire logic collOverflowSet,
	input wire logic [9:0] collCountBits,
	// outputs toward the rest of the receiver
	output logic irq,
	output logic skipFrame,
	output logic useDma,
	output logic useStreaming,
	output logic frameDiscard,
	output logic [10:0] storedLength
);
	// =====================================================
	// configuration register
	logic [15:0] cfg_ff;
	logic cfgHit;
	logic [15:0] nxt_cfg;
	assign cfgHit = !ioMode && regAddr == resq_pkg::RECEIVE_CONFIG_OFS;
	always_comb begin
		nxt_cfg = {regWrData[15:6], resq_pkg::RECEIVE_CONFIG_RST[5:0]};
		// skip is act-once, never stored
		nxt_cfg[resq_pkg::CFG_SKIP] = 1'b0;
	end

	// RULE_13: reset value, memory override
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_ff <= resq_pkg::RECEIVE_CONFIG_RST;
		end else if (regWr && cfgHit) begin
			cfg_ff <= nxt_cfg;
		end else if (cfgMemLoad && cfgMemPresent) begin
			cfg_ff <= {cfgMemValue[15:7], 1'b0, resq_pkg::RECEIVE_CONFIG_RST[5:0]};
		end
	end

	// RULE_05: one pulse per write of one, none while dma-only is set
	logic skip_ff;
	always_ff @(posedge mclk) begin
		if (rst) begin
			skip_ff <= 1'b0;
		end else begin
			skip_ff <= regWr && cfgHit && regWrData[resq_pkg::CFG_SKIP] && !cfg_ff[resq_pkg::CFG_DMA_ONLY];
		end
	end
	assign skipFrame = skip_ff;

	// =====================================================
	// transfer path selection
	resq_pkg::resq_path_e pathSel;
	// RULE_10: dma-only has precedence
	always_comb begin
		case ({cfg_ff[resq_pkg::CFG_DMA_ONLY], cfg_ff[resq_pkg::CFG_AUTO_DMA]})
			2'b10, 2'b11: pathSel = resq_pkg::RESQ_DMA_ONLY;
			2'b01: pathSel = resq_pkg::RESQ_DMA_AUTO;
			default: pathSel = resq_pkg::RESQ_DMA_NONE;
		endcase
	end
	assign useDma = pathSel == resq_pkg::RESQ_DMA_ONLY ||
		(pathSel == resq_pkg::RESQ_DMA_AUTO && autoDmaCondition);
	// RULE_07: streaming only for filtered back-to-back frames
	assign useStreaming = cfg_ff[resq_pkg::CFG_STREAM] && backToBack && filterPass;

	// =====================================================
	// frame classification
	logic isShort;
	logic isLong;
	logic isGood;
	logic tooTiny;
	logic hashedHit;
	// RULE_12: tiny frames dropped silently
	assign tooTiny = frameBytes < resq_pkg::DISCARD_BELOW;
	// RULE_20: short, overlong, bad fcs
	assign isShort = frameBytes < resq_pkg::MIN_FRAME;
	assign isLong = frameBytes > resq_pkg::MAX_FRAME;
	// RULE_16: good means fcs and length both fine
	assign isGood = fcsOk && !isShort && !isLong;
	assign hashedHit = hashAccepted && (multicastDest || stationHashAccept);
	assign frameDiscard = frameDone && tooTiny;

	logic [15:0] newEvent;
	always_comb begin
		newEvent = {10'h000, resq_pkg::NUM_RX_EVENT};
		newEvent[resq_pkg::EV_GOOD] = isGood;
		newEvent[resq_pkg::EV_HASHED] = hashedHit;
		// RULE_15: trailing partial byte
		newEvent[resq_pkg::EV_EXTRA_BITS] = extraBits;
		// RULE_14: station hash hit qualified
		newEvent[resq_pkg::EV_HASH_HIT] = hashAccepted && stationHashAccept && hashedHit;
		// RULE_17: hash index replaces flags
		if (hashedHit && isGood) begin
			newEvent[15:10] = hashIndex;
		end else begin
			// RULE_18: own address qualified
			newEvent[resq_pkg::EV_OWN] = stationMatch && isGood && ownAddressAccept;
			// RULE_19: all-ones destination qualified
			newEvent[resq_pkg::EV_ALL_ONES] = allOnesDest && isGood && allOnesDestAccept;
			// RULE_20: error flags
			newEvent[resq_pkg::EV_BAD_FCS] = !fcsOk;
			newEvent[resq_pkg::EV_SHORT] = isShort;
			newEvent[resq_pkg::EV_LONG] = isLong;
			newEvent[15] = 1'b0;
		end
	end

	// RULE_11: length with or without fcs, capped at max
	logic [10:0] lenCap;
	assign lenCap = isLong ? resq_pkg::MAX_FRAME : frameBytes;
	always_ff @(posedge mclk) begin
		if (rst) begin
			storedLength <= 11'h000;
		end else if (frameDone && !tooTiny) begin
			storedLength <= (cfg_ff[resq_pkg::CFG_KEEP_FCS] || lenCap < resq_pkg::FCS_BYTES) ? lenCap :
				11'(lenCap - resq_pkg::FCS_BYTES);
		end
	end

	// =====================================================
	// receive event and status copy
	logic [15:0] event_ff;
	logic [15:0] status_ff;
	logic evRead;
	logic rxLatch;
	assign evRead = regRd && !ioMode && regAddr == resq_pkg::RECEIVE_EVENT_OFS;
	assign rxLatch = frameDone && !tooTiny;

	// RULE_21: read clears, new frame wins
	always_ff @(posedge mclk) begin
		if (rst) begin
			event_ff <= {10'h000, resq_pkg::NUM_RX_EVENT};
		end else if (rxLatch) begin
			event_ff <= newEvent;
		end else if (evRead) begin
			event_ff <= {10'h000, resq_pkg::NUM_RX_EVENT};
		end
	end

	// RULE_22: copy not cleared by reads
	always_ff @(posedge mclk) begin
		if (rst) begin
			status_ff <= {10'h000, resq_pkg::NUM_RX_EVENT};
		end else if (rxLatch) begin
			status_ff <= newEvent;
		end
	end

	// RULE_09: no good-frame interrupt on dma frames
	logic goodIntr;
	assign goodIntr = isGood && cfg_ff[resq_pkg::CFG_GOOD_IE] && !useDma;
	// RULE_12: per-error enables
	logic badFcsIntr;
	logic shortIntr;
	logic longIntr;
	assign badFcsIntr = !fcsOk && cfg_ff[resq_pkg::CFG_BAD_FCS_IE];
	assign shortIntr = isShort && cfg_ff[resq_pkg::CFG_SHORT_IE];
	// overlong interrupt does not care about fcs state
	assign longIntr = isLong && cfg_ff[resq_pkg::CFG_LONG_IE];
	logic rxIntr;
	assign rxIntr = rxLatch && (goodIntr || badFcsIntr || shortIntr || longIntr);

	// =====================================================
	// interrupt status queue
	logic [resq_pkg::NUM_SOURCES-1:0] srcSet;
	logic [9:0] srcBits [resq_pkg::NUM_SOURCES];
	logic [resq_pkg::NUM_SOURCES-1:0] srcPend;
	logic [9:0] srcHeld [resq_pkg::NUM_SOURCES];
	logic [resq_pkg::NUM_SOURCES-1:0] srcTake;
	logic [5:0] srcNum [resq_pkg::NUM_SOURCES];
	logic qRead;

	assign srcSet = {collOverflowSet, missOverflowSet, bufEventSet, txEventSet, rxIntr};
	assign srcBits[resq_pkg::SRC_RX] = newEvent[15:6];
	assign srcBits[resq_pkg::SRC_TX] = txEventBits;
	assign srcBits[resq_pkg::SRC_BUF] = bufEventBits;
	assign srcBits[resq_pkg::SRC_MISS] = missCountBits;
	assign srcBits[resq_pkg::SRC_COLL] = collCountBits;
	assign srcNum[resq_pkg::SRC_RX] = resq_pkg::NUM_RX_EVENT;
	assign srcNum[resq_pkg::SRC_TX] = resq_pkg::NUM_TX_EVENT;
	assign srcNum[resq_pkg::SRC_BUF] = resq_pkg::NUM_BUF_EVENT;
	assign srcNum[resq_pkg::SRC_MISS] = resq_pkg::NUM_MISS_CNT;
	assign srcNum[resq_pkg::SRC_COLL] = resq_pkg::NUM_COLL_CNT;

	// RULE_03: memory and io addresses
	assign qRead = regRd && (ioMode ? regAddr == resq_pkg::QUEUE_IO_OFS : regAddr == resq_pkg::QUEUE_OFS);

	// RULE_23: lowest pending source first, one per read
	logic [15:0] qWord;
	always_comb begin
		qWord = resq_pkg::QUEUE_RST;
		srcTake = '0;
		for (int i = resq_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
			if (srcPend[i]) begin
				// RULE_02: number low, content high
				qWord = {srcHeld[i], srcNum[i]};
				srcTake = '0;
				srcTake[i] = qRead;
			end
		end
	end

	// RULE_01: hold content per source until presented
	// receive event slot
	resq_pend_slot uSlotRx (
		.mclk(mclk),
		.rst(rst),
		.setReq(srcSet[resq_pkg::SRC_RX]),
		.setBits(srcBits[resq_pkg::SRC_RX]),
		.take(srcTake[resq_pkg::SRC_RX]),
		.pending(srcPend[resq_pkg::SRC_RX]),
		.bits(srcHeld[resq_pkg::SRC_RX])
	);

	// transmit event slot
	resq_pend_slot uSlotTx (
		.mclk(mclk),
		.rst(rst),
		.setReq(srcSet[resq_pkg::SRC_TX]),
		.setBits(srcBits[resq_pkg::SRC_TX]),
		.take(srcTake[resq_pkg::SRC_TX]),
		.pending(srcPend[resq_pkg::SRC_TX]),
		.bits(srcHeld[resq_pkg::SRC_TX])
	);

	// buffer event slot
	resq_pend_slot uSlotBuf (
		.mclk(mclk),
		.rst(rst),
		.setReq(srcSet[resq_pkg::SRC_BUF]),
		.setBits(srcBits[resq_pkg::SRC_BUF]),
		.take(srcTake[resq_pkg::SRC_BUF]),
		.pending(srcPend[resq_pkg::SRC_BUF]),
		.bits(srcHeld[resq_pkg::SRC_BUF])
	);

	// missed frame counter overflow slot
	resq_pend_slot uSlotMiss (
		.mclk(mclk),
		.rst(rst),
		.setReq(srcSet[resq_pkg::SRC_MISS]),
		.setBits(srcBits[resq_pkg::SRC_MISS]),
		.take(srcTake[resq_pkg::SRC_MISS]),
		.pending(srcPend[resq_pkg::SRC_MISS]),
		.bits(srcHeld[resq_pkg::SRC_MISS])
	);

	// collision counter overflow slot
	resq_pend_slot uSlotColl (
		.mclk(mclk),
		.rst(rst),
		.setReq(srcSet[resq_pkg::SRC_COLL]),
		.setBits(srcBits[resq_pkg::SRC_COLL]),
		.take(srcTake[resq_pkg::SRC_COLL]),
		.pending(srcPend[resq_pkg::SRC_COLL]),
		.bits(srcHeld[resq_pkg::SRC_COLL])
	);

	// RULE_01: request high while anything pending
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(srcSet | (srcPend & ~srcTake));
		end
	end

	// =====================================================
	// read data, registered one cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdData <= 16'h0000;
		end else if (qRead) begin
			regRdData <= qWord;
		end else if (regRd && !ioMode) begin
			case (regAddr)
				resq_pkg::RECEIVE_CONFIG_OFS: regRdData <= cfg_ff;
				// RULE_04: number code in low bits
				resq_pkg::RECEIVE_EVENT_OFS: regRdData <= {event_ff[15:6], resq_pkg::NUM_RX_EVENT};
				resq_pkg::RECEIVE_STATUS_COPY_OFS: regRdData <= status_ff;
				resq_pkg::FRAME_LENGTH_OFS: regRdData <= {5'h00, storedLength};
				default: regRdData <= 16'h0000;
			endcase
		end else begin
			regRdData <= 16'h0000;
		end
	end
endmodule

// [verif/resq_rx_event_queue_monitor.sv]
`timescale 1ns/1ps
module resq_rx_event_queue_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ioMode,
	input wire logic [15:0] regAddr,
	input wire logic regRd,
	input wire logic regWr,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic frameDone,
	input wire logic [10:0] frameBytes,
	input wire logic backToBack,
	input wire logic filterPass,
	input wire logic txEventSet,
	input wire logic irq,
	input wire logic skipFrame,
	input wire logic useStreaming,
	input wire logic frameDiscard,
	input wire logic [10:0] storedLength
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic rdQueue;
	assign rdQueue = regRd && (ioMode ? regAddr == resq_pkg::QUEUE_IO_OFS : regAddr == resq_pkg::QUEUE_OFS);
	sequence skipWrite;
		regWr && !ioMode && regAddr == resq_pkg::RECEIVE_CONFIG_OFS && regWrData[6];
	endsequence
	sequence skipPulse;
		skipFrame ##1 !skipFrame;
	endsequence
	a_skip_once: assert property (skipFrame |-> skipPulse)
		else $error("skip pulse longer than one cycle");
	a_skip_cause: assert property ($rose(skipFrame) |-> $past(regWr) && $past(regWrData[6]))
		else $error("skip pulse without a skip write");
	a_event_id_bits: assert property (regRd && !ioMode && regAddr == resq_pkg::RECEIVE_EVENT_OFS
		|=> regRdData[5:0] == resq_pkg::NUM_RX_EVENT) else $error("event id bits wrong");
	a_queue_empty: assert property (rdQueue && !irq |=> regRdData == 16'h0000)
		else $error("empty queue read not zero");
	a_queue_number: assert property (rdQueue && irq |=> regRdData[5:0] inside {6'h04, 6'h08, 6'h0c, 6'h10, 6'h12})
		else $error("queue register number bad");
	a_irq_on_event: assert property (txEventSet |=> irq)
		else $error("no interrupt after event");
	a_idle_read_zero: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data without read");
	a_discard_short: assert property (frameDiscard == (frameDone && frameBytes < resq_pkg::DISCARD_BELOW))
		else $error("short frame discard wrong");
	a_length_cap: assert property (storedLength <= resq_pkg::MAX_FRAME)
		else $error("stored length above cap");
	a_stream_gate: assert property (useStreaming |-> backToBack && filterPass)
		else $error("streaming without back to back pass");
endmodule

// [verif/resq_host_model.sv]
`timescale 1ns/1ps
// host side of the register port; idle address is inverted so stale values never match
module resq_host_model (
	input wire logic mclk,
	input wire logic [15:0] regRdData,
	output logic [15:0] regAddr,
	output logic regRd,
	output logic regWr,
	output logic [15:0] regWrData
);
	initial begin
		regAddr = 16'hffff;
		regRd = 1'b0;
		regWr = 1'b0;
		regWrData = 16'h0000;
	end
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge mclk);
		regAddr = a;
		regRd = 1'b1;
		@(negedge mclk);
		regRd = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask
	// callers never pair skip with dma-only, nor streaming alone
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(negedge mclk);
		regAddr = a;
		regWrData = v;
		regWr = 1'b1;
		@(negedge mclk);
		regWr = 1'b0;
		regAddr = ~a;
		regWrData = ~v;
	endtask
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
	logic mclk, rst, ioMode, frameDone, fcsOk, extraBits, hashAccepted, stationMatch, allOnesDest;
	logic backToBack, filterPass, autoDmaCondition, stationHashAccept, ownAddressAccept, allOnesDestAccept;
	logic regRd, regWr, irq, skipFrame, useDma, useStreaming, frameDiscard;
	logic [15:0] regAddr, regWrData, regRdData;
	logic [10:0] frameBytes, storedLength;
	logic [5:0] hashIndex;
	logic [3:0] srcSet;
	logic [9:0] srcBits [4];
	logic [5:0] nums [4] = '{resq_pkg::NUM_TX_EVENT, resq_pkg::NUM_BUF_EVENT, resq_pkg::NUM_MISS_CNT, resq_pkg::NUM_COLL_CNT};
	int errors = 0;
	int cmpCount = 0;
	int cycles = 0;
	localparam logic [15:0] CFG = resq_pkg::RECEIVE_CONFIG_OFS;
	localparam logic [15:0] EVT = resq_pkg::RECEIVE_EVENT_OFS;
	localparam logic [15:0] QUE = resq_pkg::QUEUE_OFS;
	resq_host_model u_host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr), .regRd(regRd), .regWr(regWr),
		.regWrData(regWrData));
	resq_rx_event_queue u_dut (.mclk(mclk), .rst(rst), .ioMode(ioMode), .regAddr(regAddr), .regRd(regRd),
		.regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .cfgMemPresent(1'b0), .cfgMemLoad(1'b0),
		.cfgMemValue(16'h0000), .frameDone(frameDone), .frameBytes(frameBytes), .fcsOk(fcsOk),
		.extraBits(extraBits), .hashAccepted(hashAccepted), .hashIndex(hashIndex), .stationMatch(stationMatch),
		.allOnesDest(allOnesDest), .multicastDest(1'b0), .backToBack(backToBack), .filterPass(filterPass),
		.autoDmaCondition(autoDmaCondition), .stationHashAccept(stationHashAccept),
		.ownAddressAccept(ownAddressAccept), .allOnesDestAccept(allOnesDestAccept), .txEventSet(srcSet[0]),
		.txEventBits(srcBits[0]), .bufEventSet(srcSet[1]), .bufEventBits(srcBits[1]), .missOverflowSet(srcSet[2]),
		.missCountBits(srcBits[2]), .collOverflowSet(srcSet[3]), .collCountBits(srcBits[3]), .irq(irq),
		.skipFrame(skipFrame), .useDma(useDma), .useStreaming(useStreaming), .frameDiscard(frameDiscard),
		.storedLength(storedLength));
	task give_verdict;
		$display("errors %0d compares %0d", errors, cmpCount);
		if (errors == 0 && cmpCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rdChk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		u_host.rd(a, d);
		`CHK($sformatf("read %h", a), e, d)
	endtask
	task automatic frm(input logic [10:0] b, input logic ok);
		@(negedge mclk);
		frameDone = 1'b1;
		frameBytes = b;
		fcsOk = ok;
		#1 `CHK("discard", b < 11'd8, frameDiscard)
		@(negedge mclk);
		frameDone = 1'b0;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ==========
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			give_verdict();
		end
	end
	// ==========
	// scenarios
	initial begin
		{rst, ioMode, frameDone, fcsOk, extraBits, hashAccepted, stationMatch, allOnesDest} = 8'h80;
		{backToBack, filterPass, autoDmaCondition, stationHashAccept, ownAddressAccept, allOnesDestAccept} = 6'h00;
		{frameBytes, hashIndex, srcSet} = '0;
		srcBits = '{10'h000, 10'h000, 10'h000, 10'h000};
		repeat (8) @(negedge mclk);
		rst = 1'b0;
		rdChk(CFG, 16'h0003);
		rdChk(EVT, 16'h0004);
		rdChk(QUE, 16'h0000);
		rdChk(16'h0200, 16'h0000);
		u_host.wr(CFG, 16'h1000);
		frm(11'd100, 1'b0);
		`CHK("irq", 1'b1, irq)
		rdChk(QUE, 16'h1004);
		`CHK("irq", 1'b0, irq)
		rdChk(resq_pkg::RECEIVE_STATUS_COPY_OFS, 16'h1004);
		u_host.wr(CFG, 16'h0100);
		frm(11'd64, 1'b1);
		`CHK("length", 11'd60, storedLength)
		rdChk(QUE, 16'h0104);
		rdChk(resq_pkg::FRAME_LENGTH_OFS, 16'd60);
		u_host.wr(CFG, 16'h0300);
		`CHK("dma", 1'b1, useDma)
		frm(11'd64, 1'b1);
		`CHK("irq", 1'b0, irq)
		autoDmaCondition = 1'b1;
		u_host.wr(CFG, 16'h0400);
		`CHK("dma", 1'b1, useDma)
		autoDmaCondition = 1'b0;
		#1 `CHK("dma", 1'b0, useDma)
		{backToBack, filterPass} = 2'b11;
		u_host.wr(CFG, 16'h0480);
		`CHK("stream", 1'b1, useStreaming)
		u_host.wr(CFG, 16'h0400);
		`CHK("stream", 1'b0, useStreaming)
		u_host.wr(CFG, 16'h0800);
		rdChk(EVT, 16'h0104);
		frm(11'd2000, 1'b1);
		`CHK("length", 11'd1518, storedLength)
		`CHK("irq", 1'b0, irq)
		rdChk(EVT, 16'h4004);
		rdChk(EVT, 16'h0004);
		u_host.wr(CFG, 16'h0000);
		{hashAccepted, stationHashAccept, hashIndex} = {2'b11, 6'h2a};
		frm(11'd64, 1'b1);
		rdChk(EVT, 16'hab44);
		{hashAccepted, stationHashAccept} = 2'b00;
		{stationMatch, ownAddressAccept, allOnesDest, extraBits} = 4'hf;
		frm(11'd64, 1'b1);
		rdChk(EVT, 16'h0584);
		{stationMatch, ownAddressAccept, allOnesDestAccept, extraBits} = 4'h2;
		frm(11'd64, 1'b1);
		rdChk(EVT, 16'h0904);
		@(negedge mclk);
		srcSet = 4'hf;
		srcBits = '{10'h001, 10'h002, 10'h004, 10'h008};
		@(negedge mclk);
		srcSet = 4'h0;
		for (int i = 0; i < 4; i++)
			rdChk(QUE, {10'h001 << i, nums[i]});
		rdChk(QUE, 16'h0000);
		ioMode = 1'b1;
		srcBits[0] = 10'h3ff;
		srcSet = 4'h1;
		@(negedge mclk);
		srcSet = 4'h0;
		rdChk(resq_pkg::QUEUE_IO_OFS, 16'hffc8);
		rdChk(CFG, 16'h0000);
		ioMode = 1'b0;
		u_host.wr(CFG, 16'h0040);
		`CHK("skip", 1'b1, skipFrame)
		@(negedge mclk);
		`CHK("skip", 1'b0, skipFrame)
		rdChk(CFG, 16'h0003);
		frm(11'd7, 1'b1);
		frm(11'd8, 1'b1);
		give_verdict();
	end
endmodule
bind resq_rx_event_queue resq_rx_event_queue_monitor u_mon (.mclk(mclk), .rst(rst), .ioMode(ioMode),
	.regAddr(regAddr), .regRd(regRd), .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData),
	.frameDone(frameDone), .frameBytes(frameBytes), .backToBack(backToBack), .filterPass(filterPass),
	.txEventSet(txEventSet), .irq(irq), .skipFrame(skipFrame), .useStreaming(useStreaming),
	.frameDiscard(frameDiscard), .storedLength(storedLength));
